/* File: rtl/wsqmf_pkg.sv */
package wsqmf_pkg;
    // ========================================
    // data path widths and frame lengths
    localparam int SAMPLE_W = 16;
    localparam int ACC_W = 40;
    localparam int TAPS_HALF = 16;
    localparam int FRAME_WB = 80;
    localparam int FRAME_NB = 40;
    localparam int BAND_LEN = 40;
    localparam int COEF_Q = 15;
    localparam logic signed [ACC_W-1:0] ROUND_HALF = 40'sh0000004000;
    localparam logic signed [15:0] SAMPLE_MAX = 16'sh7FFF;
    localparam logic signed [15:0] SAMPLE_MIN = 16'sh8000;
    // feedback coefficients in Q15: 0.984375 and 0.96875
    localparam logic signed [15:0] HPF_WB_COEF = 16'sh7E00;
    localparam logic signed [15:0] HPF_NB_COEF = 16'sh7C00;
    // even-phase split taps in Q15; odd phase is the same set reversed
    localparam logic signed [15:0] QMF_H0 [TAPS_HALF] = '{
        16'shFFEB, 16'shFFD7, 16'sh002F, 16'shFFFA, 16'shFF79, 16'sh01DA, 16'shFAFA, 16'sh1072,
        16'sh3BB5, 16'shF33A, 16'sh06C6, 16'shFC03, 16'sh024A, 16'shFECD, 16'sh0088, 16'shFFD4};
    // ========================================
    // layer bit budget per frame
    localparam int CODE_BITS = 8;
    localparam int CORE_BITS = CODE_BITS * BAND_LEN;
    localparam int LOWER_ENH_BITS = 80;
    localparam int GAIN_BITS = 8;
    localparam int VQ_IDX_BITS = 5;
    localparam int VQ_SIGN_BITS = 1;
    localparam int SUBVECTORS = 6;
    localparam int HIGHER_ENH_BITS = GAIN_BITS + 2 * SUBVECTORS * (VQ_IDX_BITS + VQ_SIGN_BITS);
    localparam int FULL_FRAME_BITS = 480;
    localparam int BITS_W = 9;
    localparam int LAYER_CORE = 0;
    localparam int LAYER_LOWER = 1;
    localparam int LAYER_HIGHER = 2;
    // ========================================
    // timing figures
    localparam int CLK_PERIOD_NS = 50;
    localparam int FRAME_TIME_US = 5000;
    localparam int LOOKAHEAD_US = 5000;
    localparam int QMF_PAIR_DELAY_NS = 1875000;
    localparam int ALG_DELAY_NS = 11875000;
    localparam int ALG_DELAY_SAMPLES = 190;
    localparam int QMF_PAIR_DELAY_CYCLES = QMF_PAIR_DELAY_NS / CLK_PERIOD_NS;
    localparam int ALG_DELAY_CYCLES = ALG_DELAY_NS / CLK_PERIOD_NS;
    // ========================================
    // coder modes: core, core+lower, core+higher, all three
    typedef enum logic [1:0] {
        WSQMF_R1 = 2'h0,
        WSQMF_R2A = 2'h1,
        WSQMF_R2B = 2'h2,
        WSQMF_R3 = 2'h3
    } wsqmf_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MAC,
        ST_OUT
    } wsqmf_state_t;
endpackage

/* File: rtl/wsqmf_front_end.sv */
`timescale 1ns/1ps
// What this block does
// - core layer is 40 codes of 8 bits
// - lower enhancement layer totals 80 bits
// - higher layer: gain, indices, signs, 80 bits
// - 5 ms frame of all layers is 480 bits
// - bitstream concatenates only the selected layers
// - whole codec delay is 190 samples
// - filterbank pair 1.875 ms, lookahead 5 ms
// - match the reference fixed-point arithmetic
// - all-zero lower layer gives zero refinement
// - all-zero higher layer gives zero coefficients
// - wideband high-pass feedback 0.984375, 80 samples
// - narrow-band high-pass feedback 0.96875, 40 samples
// - lower band is low-pass, keep odd outputs
// - higher band flips odd tap signs
// - lower band is even plus odd phase
// - higher band is odd minus even phase
// - narrow band bypasses split to lower band
// - four modes, middle two signalled externally
module wsqmf_front_end
    import wsqmf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // operating mode, sampled at the first sample of a frame
    input wire logic narrowBand,
    input wire logic [1:0] modeSel,
    // sample stream in
    input wire logic signed [SAMPLE_W-1:0] widebandInput,
    input wire logic sampleValid,
    output logic inReady,
    // band samples out
    output logic signed [SAMPLE_W-1:0] lowerBandOutput,
    output logic signed [SAMPLE_W-1:0] higherBandOutput,
    output logic bandValid,
    output logic frameDone,
    // layer budget of the current frame
    output logic [2:0] layerMask,
    output logic [BITS_W-1:0] frameBits
);
    // ========================================
    // saturation to a 16-bit sample
    function automatic logic signed [SAMPLE_W-1:0] sat16(input logic signed [ACC_W-1:0] v);
        if (v > ACC_W'(SAMPLE_MAX)) begin
            sat16 = SAMPLE_MAX;
        end else if (v < ACC_W'(SAMPLE_MIN)) begin
            sat16 = SAMPLE_MIN;
        end else begin
            sat16 = v[SAMPLE_W-1:0];
        end
    endfunction

    // ========================================
    // state
    wsqmf_state_t state_r, state_nxt;
    logic narrow_r, narrow_nxt;
    logic [2:0] layerMask_r, layerMask_nxt;
    logic [BITS_W-1:0] frameBits_r, frameBits_nxt;
    logic [6:0] inCount_r, inCount_nxt;
    logic [5:0] outCount_r, outCount_nxt;
    logic [3:0] macIdx_r, macIdx_nxt;
    logic signed [SAMPLE_W-1:0] prevIn_r, prevIn_nxt;
    logic signed [SAMPLE_W-1:0] prevOut_r, prevOut_nxt;
    logic signed [SAMPLE_W-1:0] evenPend_r, evenPend_nxt;
    logic signed [SAMPLE_W-1:0] evenHist_r [TAPS_HALF];
    logic signed [SAMPLE_W-1:0] evenHist_nxt [TAPS_HALF];
    logic signed [SAMPLE_W-1:0] oddHist_r [TAPS_HALF];
    logic signed [SAMPLE_W-1:0] oddHist_nxt [TAPS_HALF];
    logic signed [ACC_W-1:0] evenAcc_r, evenAcc_nxt;
    logic signed [ACC_W-1:0] oddAcc_r, oddAcc_nxt;
    logic inReady_r, inReady_nxt;
    logic signed [SAMPLE_W-1:0] lower_r, lower_nxt;
    logic signed [SAMPLE_W-1:0] higher_r, higher_nxt;
    logic bandValid_r, bandValid_nxt;
    logic frameDone_r, frameDone_nxt;

    logic accept;
    logic firstOfFrame;
    logic narrowNow;
    logic [2:0] maskNow;
    logic signed [15:0] hpfCoef;
    logic signed [ACC_W-1:0] feedback;
    logic signed [ACC_W-1:0] hpfSum;
    logic signed [SAMPLE_W-1:0] hpfOut;
    logic [BITS_W-1:0] bitsNow;

    assign accept = sampleValid && inReady_r;
    assign firstOfFrame = (inCount_r == 7'h00);

    always_comb begin
        narrowNow = firstOfFrame ? narrowBand : narrow_r;
        // the bitstream alone cannot tell the two middle modes apart
        case (wsqmf_mode_t'(modeSel))
            WSQMF_R1: maskNow = 3'h1;
            WSQMF_R2A: maskNow = 3'h3;
            WSQMF_R2B: maskNow = 3'h5;
            WSQMF_R3: maskNow = 3'h7;
            default: maskNow = 3'h1;
        endcase
        // unselected layers contribute nothing; a decoder sees them as zero
        bitsNow = (maskNow[LAYER_CORE] ? BITS_W'(CORE_BITS) : '0)
            + (maskNow[LAYER_LOWER] ? BITS_W'(LOWER_ENH_BITS) : '0)
            + (maskNow[LAYER_HIGHER] ? BITS_W'(HIGHER_ENH_BITS) : '0);
        // first-order DC removal, Q15 feedback with rounding
        hpfCoef = narrowNow ? HPF_NB_COEF : HPF_WB_COEF;
        feedback = (ACC_W'(hpfCoef) * ACC_W'(prevOut_r) + ROUND_HALF) >>> COEF_Q;
        hpfSum = feedback + ACC_W'(widebandInput) - ACC_W'(prevIn_r);
        hpfOut = sat16(hpfSum);
    end

    // ========================================
    // next-state logic
    always_comb begin
        state_nxt = state_r;
        narrow_nxt = narrow_r;
        layerMask_nxt = layerMask_r;
        frameBits_nxt = frameBits_r;
        inCount_nxt = inCount_r;
        outCount_nxt = outCount_r;
        macIdx_nxt = macIdx_r;
        prevIn_nxt = prevIn_r;
        prevOut_nxt = prevOut_r;
        evenPend_nxt = evenPend_r;
        evenHist_nxt = evenHist_r;
        oddHist_nxt = oddHist_r;
        evenAcc_nxt = evenAcc_r;
        oddAcc_nxt = oddAcc_r;
        inReady_nxt = inReady_r;
        lower_nxt = lower_r;
        higher_nxt = higher_r;
        bandValid_nxt = 1'b0;
        frameDone_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    if (firstOfFrame) begin
                        narrow_nxt = narrowBand;
                        layerMask_nxt = maskNow;
                        frameBits_nxt = bitsNow;
                    end
                    prevIn_nxt = widebandInput;
                    prevOut_nxt = hpfOut;
                    inCount_nxt = inCount_r + 7'h01;
                    if (narrowNow) begin
                        // no split at 8 kHz: filtered sample is the lower band
                        lower_nxt = hpfOut;
                        higher_nxt = '0;
                        state_nxt = ST_OUT;
                        inReady_nxt = 1'b0;
                    end else if (!inCount_r[0]) begin
                        evenPend_nxt = hpfOut;
                    end else begin
                        // odd sample completes a pair: shift both phase lines
                        for (int k = TAPS_HALF - 1; k > 0; k--) begin
                            evenHist_nxt[k] = evenHist_r[k-1];
                            oddHist_nxt[k] = oddHist_r[k-1];
                        end
                        evenHist_nxt[0] = evenPend_r;
                        oddHist_nxt[0] = hpfOut;
                        evenAcc_nxt = '0;
                        oddAcc_nxt = '0;
                        macIdx_nxt = '0;
                        state_nxt = ST_MAC;
                        inReady_nxt = 1'b0;
                    end
                end
            end
            ST_MAC: begin
                // one tap pair per cycle; input stalls for the 16 cycles here and the ST_OUT cycle, 17 in all
                evenAcc_nxt = evenAcc_r
                    + ACC_W'(QMF_H0[macIdx_r]) * ACC_W'(evenHist_r[macIdx_r]);
                oddAcc_nxt = oddAcc_r
                    + ACC_W'(QMF_H0[4'hF - macIdx_r]) * ACC_W'(oddHist_r[macIdx_r]);
                macIdx_nxt = macIdx_r + 4'h1;
                if (macIdx_r == 4'hF) begin
                    state_nxt = ST_OUT;
                    lower_nxt = sat16((evenAcc_nxt + oddAcc_nxt + ROUND_HALF) >>> COEF_Q);
                    higher_nxt = sat16((oddAcc_nxt - evenAcc_nxt + ROUND_HALF) >>> COEF_Q);
                end
            end
            ST_OUT: begin
                bandValid_nxt = 1'b1;
                inReady_nxt = 1'b1;
                state_nxt = ST_IDLE;
                if (outCount_r == 6'(BAND_LEN - 1)) begin
                    outCount_nxt = '0;
                    inCount_nxt = '0;
                    frameDone_nxt = 1'b1;
                end else begin
                    outCount_nxt = outCount_r + 6'h01;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // ========================================
    // registers
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            narrow_r <= 1'b0;
            layerMask_r <= 3'h7;
            frameBits_r <= BITS_W'(FULL_FRAME_BITS);
            inCount_r <= '0;
            outCount_r <= '0;
            macIdx_r <= '0;
            prevIn_r <= '0;
            prevOut_r <= '0;
            evenPend_r <= '0;
            evenAcc_r <= '0;
            oddAcc_r <= '0;
            inReady_r <= 1'b1;
            lower_r <= '0;
            higher_r <= '0;
            bandValid_r <= 1'b0;
            frameDone_r <= 1'b0;
            for (int k = 0; k < TAPS_HALF; k++) begin
                evenHist_r[k] <= '0;
                oddHist_r[k] <= '0;
            end
        end else begin
            state_r <= state_nxt;
            narrow_r <= narrow_nxt;
            layerMask_r <= layerMask_nxt;
            frameBits_r <= frameBits_nxt;
            inCount_r <= inCount_nxt;
            outCount_r <= outCount_nxt;
            macIdx_r <= macIdx_nxt;
            prevIn_r <= prevIn_nxt;
            prevOut_r <= prevOut_nxt;
            evenPend_r <= evenPend_nxt;
            evenAcc_r <= evenAcc_nxt;
            oddAcc_r <= oddAcc_nxt;
            inReady_r <= inReady_nxt;
            lower_r <= lower_nxt;
            higher_r <= higher_nxt;
            bandValid_r <= bandValid_nxt;
            frameDone_r <= frameDone_nxt;
            evenHist_r <= evenHist_nxt;
            oddHist_r <= oddHist_nxt;
        end
    end

    assign inReady = inReady_r;
    assign lowerBandOutput = lower_r;
    assign higherBandOutput = higher_r;
    assign bandValid = bandValid_r;
    assign frameDone = frameDone_r;
    assign layerMask = layerMask_r;
    assign frameBits = frameBits_r;

    // ========================================
    // checks
    AST_CORE_ALWAYS: assert property (@(posedge ref_clk) disable iff (!rstn)
        layerMask_r[LAYER_CORE] && CORE_BITS == 320) else $error("core layer missing");
    AST_LOWER_BUDGET: assert property (@(posedge ref_clk) disable iff (!rstn)
        (layerMask_r == 3'h3) |-> frameBits_r == 9'h190) else $error("R2a not 400 bits");
    AST_HIGHER_BUDGET: assert property (@(posedge ref_clk) disable iff (!rstn)
        (layerMask_r == 3'h5) |-> frameBits_r == 9'h190) else $error("R2b not 400 bits");
    AST_FULL_FRAME: assert property (@(posedge ref_clk) disable iff (!rstn)
        (layerMask_r == 3'h7) |-> frameBits_r == 9'h1E0) else $error("full frame not 480");
    AST_CORE_ONLY: assert property (@(posedge ref_clk) disable iff (!rstn)
        (layerMask_r == 3'h1) |-> frameBits_r == 9'h140) else $error("R1 not 320 bits");
    AST_MAC_LATENCY: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_r == ST_MAC && macIdx_r == 4'h0) |-> ##17 bandValid_r)
        else $error("band pair late");
    AST_NARROW_BYPASS: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bandValid_r && narrow_r) |-> higher_r == '0) else $error("narrow higher band");
    AST_STALL: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_r != ST_IDLE) |-> !inReady_r) else $error("ready while busy");
    AST_DONE_PULSE: assert property (@(posedge ref_clk) disable iff (!rstn)
        frameDone_r |-> bandValid_r ##1 !frameDone_r) else $error("done not a pulse");
    // delay figures are bookkeeping only: nothing here holds samples that long
    localparam int NS_PER_US = 1000;
    AST_DELAY_SPLIT: assert property (@(posedge ref_clk) disable iff (!rstn)
        ALG_DELAY_NS == QMF_PAIR_DELAY_NS + (FRAME_TIME_US + LOOKAHEAD_US) * NS_PER_US)
        else $error("delay budget does not add up");
endmodule

/* File: tb/wsqmf_sample_source.sv */
`timescale 1ns/1ps
// ========================================
// sample source: one frame per start request
module wsqmf_sample_source
    import wsqmf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // frame request
    input wire logic start,
    input wire logic slow,
    input wire logic [6:0] nSamples,
    input wire logic [15:0] baseVal,
    input wire logic [15:0] stepVal,
    // stream towards the block
    input wire logic inReady,
    output logic signed [SAMPLE_W-1:0] widebandInput,
    output logic sampleValid
);
    logic takenR = 1'b0;
    logic startR = 1'b0;
    logic busy = 1'b0;
    logic gap = 1'b0;
    int idx = 0;
    initial widebandInput = 16'h0000;
    initial sampleValid = 1'b0;
    always @(posedge ref_clk) begin
        takenR <= sampleValid && inReady;
        startR <= start;
    end
    // sample held until taken; idle data toggles so no stale value is read
    always @(negedge ref_clk) begin
        if (!rstn) begin
            busy = 1'b0;
        end else if (startR && !busy) begin
            busy = 1'b1;
            idx = 0;
        end else if (busy && takenR) begin
            idx++;
            gap = slow;
        end
        if (idx >= int'(nSamples)) busy = 1'b0;
        if (busy && !gap) begin
            sampleValid <= 1'b1;
            widebandInput <= baseVal + 16'(idx) * stepVal;
        end else begin
            sampleValid <= 1'b0;
            widebandInput <= ~widebandInput;
            gap = 1'b0;
        end
    end
endmodule

/* File: tb/wsqmf_front_end_tb.sv */
`timescale 1ns/1ps
module wsqmf_front_end_tb
    import wsqmf_pkg::*;
;
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] mask;
        logic [8:0] bits;
        logic slow;
        logic [15:0] base;
        logic [15:0] step;
    } wsqmf_row_t;
    // ramps after the first chosen to wrap, so the high-pass output saturates
    localparam wsqmf_row_t ROWS [4] = '{
        '{2'h0, 3'h1, 9'h140, 1'b0, 16'h0100, 16'h00C8},
        '{2'h1, 3'h3, 9'h190, 1'b1, 16'h8000, 16'h0FA1},
        '{2'h2, 3'h5, 9'h190, 1'b0, 16'h1234, 16'hF00D},
        '{2'h3, 3'h7, 9'h1E0, 1'b0, 16'h7FFF, 16'h7FFF}};
    logic ref_clk, rstn, narrowBand, sampleValid, inReady, bandValid, frameDone;
    logic start, slow;
    logic [1:0] modeSel;
    logic [2:0] layerMask;
    logic [8:0] frameBits;
    logic [6:0] nSamples;
    logic [15:0] baseVal, stepVal;
    logic signed [15:0] widebandInput, lowerBandOutput, higherBandOutput;
    int errCount = 0, nCompared = 0, cyc = 0, lastTake = 0, bandCnt = 0, frames = 0;
    int hpX1, hpY1, odd, y, ev [16], od [16], expLo [$], expHi [$];
    longint aLo, aHi;
    wsqmf_front_end i_dut (.ref_clk(ref_clk), .rstn(rstn), .narrowBand(narrowBand),
        .modeSel(modeSel), .widebandInput(widebandInput), .sampleValid(sampleValid),
        .inReady(inReady), .lowerBandOutput(lowerBandOutput),
        .higherBandOutput(higherBandOutput), .bandValid(bandValid), .frameDone(frameDone),
        .layerMask(layerMask), .frameBits(frameBits));
    wsqmf_sample_source i_src (.ref_clk(ref_clk), .rstn(rstn), .start(start), .slow(slow),
        .nSamples(nSamples), .baseVal(baseVal), .stepVal(stepVal), .inReady(inReady),
        .widebandInput(widebandInput), .sampleValid(sampleValid));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    function automatic int sat16(longint v);
        return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : int'(v));
    endfunction
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ========================================
    // reference model and output monitor
    always @(posedge ref_clk) begin
        cyc++;
        if (!rstn) begin
            hpX1 = 0; hpY1 = 0; odd = 0; bandCnt = 0;
            ev = '{default: 0}; od = '{default: 0};
            expLo.delete(); expHi.delete();
        end else begin
            if (bandValid === 1'b1) begin
                bandCnt++;
                chk(lowerBandOutput, (expLo.size() > 0) ? expLo.pop_front() : 0);
                chk(higherBandOutput, (expHi.size() > 0) ? expHi.pop_front() : 0);
                chk(frameDone, bandCnt == 40);
                chk(inReady, 1'b1);
                chk(cyc - lastTake, narrowBand ? 2 : 18);
                if (bandCnt == 40) bandCnt = 0;
                if (bandCnt == 0) frames++;
            end else chk(frameDone, 1'b0);
            if (sampleValid && inReady) begin
                aLo = longint'(narrowBand ? int'(0.96875 * 32768) : int'(0.984375 * 32768));
                y = sat16(((aLo * hpY1 + 16384) >>> 15) + int'(widebandInput) - hpX1);
                hpX1 = int'(widebandInput);
                hpY1 = y;
                if (narrowBand) begin
                    expLo.push_back(y);
                    expHi.push_back(0);
                    lastTake = cyc;
                end else if (odd == 0) begin
                    for (int i = 15; i > 0; i--) ev[i] = ev[i-1];
                    ev[0] = y;
                    odd = 1;
                end else begin
                    for (int i = 15; i > 0; i--) od[i] = od[i-1];
                    od[0] = y;
                    aLo = 0;
                    aHi = 0;
                    for (int i = 0; i < 16; i++) begin
                        aLo += QMF_H0[i] * ev[i] + QMF_H0[15-i] * od[i];
                        aHi += QMF_H0[15-i] * od[i] - QMF_H0[i] * ev[i];
                    end
                    expLo.push_back(sat16((aLo + 16384) >>> 15));
                    expHi.push_back(sat16((aHi + 16384) >>> 15));
                    lastTake = cyc;
                    odd = 0;
                end
            end
        end
    end
    // ========================================
    // sequence
    task automatic rst_chk();
        chk(inReady, 1'b1);
        chk({bandValid, frameDone, lowerBandOutput, higherBandOutput}, 34'h0);
        chk(layerMask, 3'h7);
        chk(frameBits, 9'h1E0);
    endtask
    task automatic run_frame();
        int target;
        target = frames + 1;
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        for (int n = 0; n < 4000 && frames < target; n++) @(negedge ref_clk);
        if (frames < target) begin
            errCount++;
            give_verdict();
        end
    endtask
    initial begin
        rstn = 1'b0; narrowBand = 1'b0; modeSel = 2'h0; start = 1'b0; slow = 1'b0;
        nSamples = 7'h50; baseVal = 16'h0000; stepVal = 16'h0000;
        repeat (4) @(negedge ref_clk);
        rst_chk();
        rstn = 1'b1;
        foreach (ROWS[r]) begin
            // rows step the rate up, the last frame steps it down again
            modeSel = ROWS[r].mode;
            slow = ROWS[r].slow;
            baseVal = ROWS[r].base;
            stepVal = ROWS[r].step;
            run_frame();
            chk(layerMask, ROWS[r].mask);
            chk(frameBits, ROWS[r].bits);
        end
        // reset in mid-frame, then a narrow-band frame from clean state
        stepVal = 16'h0321;
        start = 1'b1;
        repeat (300) @(negedge ref_clk);
        start = 1'b0;
        rstn = 1'b0;
        repeat (4) @(negedge ref_clk);
        rst_chk();
        rstn = 1'b1;
        narrowBand = 1'b1;
        modeSel = 2'h1;
        nSamples = 7'h28;
        run_frame();
        chk(layerMask, 3'h3);
        chk(frameBits, 9'h190);
        give_verdict();
    end
endmodule
